// *** verilog/tcc_top.v ***
// Timer compare/capture unit: 16-bit counter, buffered compares, capture/compare 2, APB slave
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "tcc_regs.vh"

// Contract
// - 16-bit counter counts either internal clocks or synced external event edges.
// - Counter held at FFFFH while count enable is 0; readback returns 0000H.
// - Count enable bit clears to 0 on reset, counter stopped.
// - Compare 0 write copies into hidden buffer; match with buffer raises match-0 request.
// - Hidden compare buffers have no software read or write path.
// - Reset clears compare 0 and its hidden buffer to 0000H.
// - Compare 1 buffered; its match inverts toggle pin and raises match-1 request.
// - Compare 1 equal to compare 0 in interval mode gives 50% square wave.
// - Capture/compare 2 role set by mode, capture-select bit and instance.
// - Capture/compare 2 accessible while counting, 16-bit wide, resets to 0000H.
// - Lowering compare 0 below count loads at once; match only after wraparound.
// - A compare above compare 0 matches in interval mode only while the count runs on after compare 0 is lowered below it.
module tcc_top #(
    parameter INSTANCE_ID = 0
) (
    input  wire                   CORE_CLK_I,
    input  wire                   NRST_I,
    input  wire                   PSEL_I,
    input  wire                   PENABLE_I,
    input  wire                   PWRITE_I,
    input  wire [`TCC_ADDR_W-1:0] PADDR_I,
    input  wire [31:0]            PWDATA_I,
    input  wire                   EVENT_I,
    input  wire                   CAPTURE_I,
    output wire [31:0]            PRDATA_O,
    output wire                   PREADY_O,
    output wire                   PSLVERR_O,
    output wire                   TOGGLE_O,
    output wire                   IRQ_O,
    output wire                   MATCH0_IRQ_O,
    output wire                   MATCH1_IRQ_O
);

    // Bus handshake states, one-hot
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ACC  = 2'b10;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    reg  [1:0]              st_q;
    reg  [1:0]              st_d;
    reg                     pready_q;
    reg                     pready_d;
    reg                     pslverr_q;
    reg                     pslverr_d;
    reg  [31:0]             prdata_q;
    reg  [31:0]             prdata_d;
    reg  [31:0]             rd_data;
    reg                     rd_hit;

    reg  [`TCC_CTRL_W-1:0]  ctrl_q;
    reg  [15:0]             cnt_q;
    reg  [15:0]             cnt_d;
    reg  [15:0]             cmp0_q;
    reg  [15:0]             buf0_q;
    reg  [15:0]             cmp1_q;
    reg  [15:0]             buf1_q;
    reg  [15:0]             cc2_q;
    reg  [15:0]             cc2_d;
    reg  [`TCC_IRQ_W-1:0]   stat_q;
    reg  [`TCC_IRQ_W-1:0]   stat_d;
    reg  [`TCC_IRQ_W-1:0]   mask_q;
    reg  [`TCC_IRQ_W-1:0]   ev;
    reg                     toggle_q;
    reg                     irq_q;
    reg                     m0_irq_q;
    reg                     m1_irq_q;

    wire                    ev_rise;
    wire                    cap_rise;
    wire                    ce;
    wire [1:0]              mode;
    wire                    ext_sel;
    wire                    ccs2;
    wire                    tick;
    wire                    cc2_capture;
    wire                    wr_en;
    wire [`TCC_IRQ_W-1:0]   clr_bits;

    ////////////////////////////////////////////////////////////////////////////
    // Pin inputs pass the synchronisers
    tcc_sync_edge u_event_sync (
        .CORE_CLK_I (CORE_CLK_I),
        .NRST_I     (NRST_I),
        .PIN_I      (EVENT_I),
        .RISE_O     (ev_rise)
    );

    tcc_sync_edge u_capture_sync (
        .CORE_CLK_I (CORE_CLK_I),
        .NRST_I     (NRST_I),
        .PIN_I      (CAPTURE_I),
        .RISE_O     (cap_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Control fields and count source
    assign ce      = ctrl_q[`TCC_CTRL_CE];
    assign mode    = ctrl_q[`TCC_CTRL_MODE_HI:`TCC_CTRL_MODE_LO];
    assign ext_sel = ctrl_q[`TCC_CTRL_EXT];
    assign ccs2    = ctrl_q[`TCC_CTRL_CCS2];

    // One count step per clock, or per event edge
    assign tick = ce & (ext_sel ? ev_rise : 1'b1);

    // Role of capture/compare 2: instance 1 is compare only
    // In compare role its match is gated into the status below
    assign cc2_capture = (INSTANCE_ID == 0) &&
                         ((mode == `TCC_MODE_PULSEW) ||
                          ((mode == `TCC_MODE_FREERUN) && ccs2));

    // Write takes effect at the access edge
    // Status bits to clear, zero unless the status register is written
    assign wr_en    = (st_q == ST_ACC) & PSEL_I & PENABLE_I & PWRITE_I;
    assign clr_bits = (wr_en && (PADDR_I == `TCC_ADDR_STAT)) ?
                      PWDATA_I[`TCC_IRQ_W-1:0] : `TCC_STAT_RST;

    ////////////////////////////////////////////////////////////////////////////
    // Counter next value and match events
    // Matches test the next count, so a request lines up with its step
    // Disable forces FFFFH at once; re-enable restarts from 0000H
    always @* begin
        cnt_d = cnt_q;
        ev    = `TCC_STAT_RST;
        if (!ce) begin
            cnt_d = `TCC_CNT_STOP;
        end else begin
            if (cap_rise && cc2_capture) begin
                ev[`TCC_IRQ_CAP] = 1'b1;
            end
            if (ev[`TCC_IRQ_CAP] && (mode == `TCC_MODE_PULSEW)) begin
                // Pulse width restarts from each captured edge
                cnt_d = `TCC_ZERO16;
            end else if (tick) begin
                if ((mode == `TCC_MODE_INTERVAL) && (cnt_q == buf0_q)) begin
                    cnt_d = `TCC_ZERO16;
                end else begin
                    // Wraps FFFFH to 0000H; also the first step after enable
                    cnt_d = cnt_q + `TCC_CNT_ONE;
                end
                ev[`TCC_IRQ_M0] = (cnt_d == buf0_q);
                ev[`TCC_IRQ_M1] = (cnt_d == buf1_q);
                ev[`TCC_IRQ_M2] = !cc2_capture && (cnt_d == cc2_q);
            end
        end
    end

    // Counter register
    // Reset value equals the stopped value, so readback starts at 0000H
    always @(posedge CORE_CLK_I) begin
        if (!NRST_I) begin
            cnt_q <= `TCC_CNT_STOP;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and compare registers with hidden buffers
    // Count register has no case item, so writes to it are dropped
    always @(posedge CORE_CLK_I) begin
        if (!NRST_I) begin
            ctrl_q <= `TCC_CTRL_RST;
            cmp0_q <= `TCC_ZERO16;
            buf0_q <= `TCC_ZERO16;
            cmp1_q <= `TCC_ZERO16;
            buf1_q <= `TCC_ZERO16;
            mask_q <= `TCC_MASK_RST;
        end else if (wr_en) begin
            case (PADDR_I)
                `TCC_ADDR_CTRL: begin
                    ctrl_q <= PWDATA_I[`TCC_CTRL_W-1:0];
                end
                `TCC_ADDR_CMP0: begin
                    // Buffer loads at once, even mid-count
                    cmp0_q <= PWDATA_I[15:0];
                    buf0_q <= PWDATA_I[15:0];
                end
                `TCC_ADDR_CMP1: begin
                    cmp1_q <= PWDATA_I[15:0];
                    buf1_q <= PWDATA_I[15:0];
                end
                `TCC_ADDR_MASK: begin
                    mask_q <= PWDATA_I[`TCC_IRQ_W-1:0];
                end
                default: begin
                    mask_q <= mask_q;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capture/compare 2: capture wins over a same-cycle write
    always @* begin
        cc2_d = cc2_q;
        if (wr_en && (PADDR_I == `TCC_ADDR_CC2)) begin
            cc2_d = PWDATA_I[15:0];
        end
        if (ev[`TCC_IRQ_CAP]) begin
            cc2_d = cnt_q;
        end
    end

    always @(posedge CORE_CLK_I) begin
        if (!NRST_I) begin
            cc2_q <= `TCC_ZERO16;
        end else begin
            cc2_q <= cc2_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Toggle pin inverts on each compare-1 match
    // Low after reset; the pin keeps its level while counting stops
    always @(posedge CORE_CLK_I) begin
        if (!NRST_I) begin
            toggle_q <= 1'b0;
        end else if (ev[`TCC_IRQ_M1]) begin
            toggle_q <= ~toggle_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky status, write one to clear; a new event wins
    always @* begin
        stat_d = (stat_q & ~clr_bits) | ev;
    end

    // Status, interrupt level and match pulses
    // Level uses the next status, so it rises with the status bit
    // Mask writes reach the level and the pulses one cycle later
    always @(posedge CORE_CLK_I) begin
        if (!NRST_I) begin
            stat_q   <= `TCC_STAT_RST;
            irq_q    <= 1'b0;
            m0_irq_q <= 1'b0;
            m1_irq_q <= 1'b0;
        end else begin
            stat_q   <= stat_d;
            irq_q    <= |(stat_d & ~mask_q);
            m0_irq_q <= ev[`TCC_IRQ_M0] & ~mask_q[`TCC_IRQ_M0];
            m1_irq_q <= ev[`TCC_IRQ_M1] & ~mask_q[`TCC_IRQ_M1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer; buffers are not visible
    // Latched at the setup edge, so a read shows the setup-cycle value
    always @* begin
        rd_data = `TCC_ZERO32;
        rd_hit  = 1'b1;
        case (PADDR_I)
            `TCC_ADDR_CTRL: begin
                rd_data[`TCC_CTRL_W-1:0] = ctrl_q;
            end
            `TCC_ADDR_COUNT: begin
                rd_data[15:0] = ce ? cnt_q : `TCC_ZERO16;
            end
            `TCC_ADDR_CMP0: begin
                rd_data[15:0] = cmp0_q;
            end
            `TCC_ADDR_CMP1: begin
                rd_data[15:0] = cmp1_q;
            end
            `TCC_ADDR_CC2: begin
                rd_data[15:0] = cc2_q;
            end
            `TCC_ADDR_STAT: begin
                rd_data[`TCC_IRQ_W-1:0] = stat_q;
            end
            `TCC_ADDR_MASK: begin
                rd_data[`TCC_IRQ_W-1:0] = mask_q;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB handshake: one wait-free access after each setup
    // Unmapped addresses answer with an error, reads and writes alike
    always @* begin
        st_d      = st_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        prdata_d  = prdata_q;
        case (st_q)
            ST_IDLE: begin
                if (PSEL_I && !PENABLE_I) begin
                    st_d      = ST_ACC;
                    pready_d  = 1'b1;
                    pslverr_d = ~rd_hit;
                    prdata_d  = PWRITE_I ? `TCC_ZERO32 : rd_data;
                end
            end
            ST_ACC: begin
                st_d     = ST_IDLE;
                prdata_d = `TCC_ZERO32;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // Bus state and answer registers
    always @(posedge CORE_CLK_I) begin
        if (!NRST_I) begin
            st_q      <= ST_IDLE;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= `TCC_ZERO32;
        end else begin
            st_q      <= st_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    // No logic between these flip-flops and the pins
    assign PRDATA_O     = prdata_q;
    assign PREADY_O     = pready_q;
    assign PSLVERR_O    = pslverr_q;
    assign TOGGLE_O     = toggle_q;
    assign IRQ_O        = irq_q;
    assign MATCH0_IRQ_O = m0_irq_q;
    assign MATCH1_IRQ_O = m1_irq_q;

endmodule // tcc_top

// *** pkg/tcc_regs.vh ***
// Register map, field positions, reset values and codes of the timer compare/capture unit
`ifndef TCC_REGS_VH
`define TCC_REGS_VH

// Byte addresses on the APB port
`define TCC_ADDR_W          8
`define TCC_ADDR_CTRL       8'h00
`define TCC_ADDR_COUNT      8'h04
`define TCC_ADDR_CMP0       8'h08
`define TCC_ADDR_CMP1       8'h0C
`define TCC_ADDR_CC2        8'h10
`define TCC_ADDR_STAT       8'h14
`define TCC_ADDR_MASK       8'h18

// Control register fields
`define TCC_CTRL_W          5
`define TCC_CTRL_CE         0
`define TCC_CTRL_MODE_LO    1
`define TCC_CTRL_MODE_HI    2
`define TCC_CTRL_EXT        3
`define TCC_CTRL_CCS2       4
`define TCC_CTRL_RST        5'h00

// Timer modes
`define TCC_MODE_INTERVAL   2'h0
`define TCC_MODE_FREERUN    2'h1
`define TCC_MODE_PULSEW     2'h2

// Interrupt status and mask fields
`define TCC_IRQ_W           4
`define TCC_IRQ_M0          0
`define TCC_IRQ_M1          1
`define TCC_IRQ_M2          2
`define TCC_IRQ_CAP         3
`define TCC_STAT_RST        4'h0
`define TCC_MASK_RST        4'hF

// Counter values
`define TCC_CNT_STOP        16'hFFFF
`define TCC_CNT_ONE         16'h0001
`define TCC_ZERO16          16'h0000
`define TCC_ZERO32          32'h00000000

`endif

// *** verilog/tcc_sync_edge.v ***
// Two-stage synchroniser with rising-edge pulse for one pin input
`timescale 1ns/1ns

module tcc_sync_edge (
    input  wire CORE_CLK_I,
    input  wire NRST_I,
    input  wire PIN_I,
    output wire RISE_O
);

    reg meta_q;
    reg sync_q;
    reg last_q;

    ////////////////////////////////////////////////////////////////////////////
    // Synchroniser; first stage feeds only the second
    always @(posedge CORE_CLK_I) begin
        if (!NRST_I) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= PIN_I;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // One-cycle pulse on a synced rising edge
    assign RISE_O = sync_q & ~last_q;

endmodule // tcc_sync_edge

// *** dv/tcc_checker.sv ***
// Assertion checker for the timer compare/capture unit
`timescale 1ns/1ns
`include "tcc_regs.vh"

module tcc_checker (
    input wire        CORE_CLK_I,
    input wire        NRST_I,
    input wire        PSEL_I,
    input wire        PENABLE_I,
    input wire        PWRITE_I,
    input wire [7:0]  PADDR_I,
    input wire [31:0] PWDATA_I,
    input wire        EVENT_I,
    input wire        CAPTURE_I,
    input wire [31:0] PRDATA_O,
    input wire        PREADY_O,
    input wire        PSLVERR_O,
    input wire        TOGGLE_O,
    input wire        IRQ_O,
    input wire        MATCH0_IRQ_O,
    input wire        MATCH1_IRQ_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!NRST_I);

    // Setup phase of the bus
    wire setup_ph = PSEL_I && !PENABLE_I;

    ////////////////////////////////////////////////////////////////////////
    // Bus timing and errors
    rdy_after_setup_a: assert property (setup_ph |=> PREADY_O) else $error("no ready after setup");
    ready_pulse_a: assert property (PREADY_O |=> !PREADY_O) else $error("ready longer than one cycle");
    err_with_ready_a: assert property (PSLVERR_O |-> PREADY_O) else $error("error without ready");
    rdata_idle_a: assert property (!PREADY_O |-> PRDATA_O == `TCC_ZERO32) else $error("read data not zero");
    unmapped_err_a: assert property (setup_ph && PADDR_I > `TCC_ADDR_MASK |=> PSLVERR_O) else $error("no error");
    count_wr_ok_a: assert property (setup_ph && PADDR_I == `TCC_ADDR_COUNT |=> !PSLVERR_O) else $error("count err");

    ////////////////////////////////////////////////////////////////////////
    // Match events
    m0_irq_level_a: assert property (MATCH0_IRQ_O |-> IRQ_O) else $error("irq low with m0");
    m1_irq_level_a: assert property (MATCH1_IRQ_O |-> IRQ_O) else $error("irq low with m1");
    m1_toggle_a: assert property (MATCH1_IRQ_O |-> TOGGLE_O != $past(TOGGLE_O)) else $error("no toggle");
    m0_pulse_a: assert property (MATCH0_IRQ_O |=> !MATCH0_IRQ_O) else $error("m0 longer than one cycle");
    m1_pulse_a: assert property (MATCH1_IRQ_O |=> !MATCH1_IRQ_O) else $error("m1 longer than one cycle");

    cover property (PSLVERR_O);
    cover property (MATCH1_IRQ_O);
    cover property ($rose(IRQ_O));
endmodule // tcc_checker

bind tcc_top tcc_checker chk_u (.CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .EVENT_I(EVENT_I), .CAPTURE_I(CAPTURE_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .TOGGLE_O(TOGGLE_O), .IRQ_O(IRQ_O), .MATCH0_IRQ_O(MATCH0_IRQ_O),
    .MATCH1_IRQ_O(MATCH1_IRQ_O));

// *** dv/tcc_tb.sv ***
// Self-checking testbench for the timer compare/capture unit
`timescale 1ns/1ns

module testbench;
    reg         clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, ev = 0, cap = 0, er, t;
    reg  [7:0]  pa  = 8'h00;
    reg  [31:0] pwd = 32'h00000000, rd;
    wire [31:0] prd;
    wire        rdy, err, tog, irq, m0, m1;
    int         n_mismatch = 0, cmp_count = 0, i, k;

    // 125 MHz clock
    always #4 clk = ~clk;

    tcc_top #(.INSTANCE_ID(0)) dut_u (.CORE_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .EVENT_I(ev), .CAPTURE_I(cap), .PRDATA_O(prd),
        .PREADY_O(rdy), .PSLVERR_O(err), .TOGGLE_O(tog), .IRQ_O(irq), .MATCH0_IRQ_O(m0), .MATCH1_IRQ_O(m1));

    // Compare and count
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer, then one idle cycle
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pen  <= 1'b0;
        pwr  <= w;
        pa   <= a;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = prd;
        er = err;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clk);
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task tally_and_finish;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Hang guard
    initial begin
        #100000;
        n_mismatch++;
        tally_and_finish;
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        cyc(2);
        nrst <= 1'b1;
        cyc(1);
        // Reset values of every register
        for (i = 0; i < 7; i++) begin
            apb(0, 8'(i * 4), 0);
            chk("reset", rd, (i == 6) ? 32'h0000000F : 32'h00000000);
        end
        // Unmapped address and read-only count
        apb(0, 8'h20, 0);
        chk("slverr", {31'h0, er}, 1);
        apb(1, 8'h04, 32'h00001234);
        apb(0, 8'h04, 0);
        chk("cnt ro", rd, 0);
        // Interval mode with compare 1 equal to compare 0
        apb(1, 8'h18, 0);
        apb(1, 8'h08, 3);
        apb(1, 8'h0C, 3);
        apb(0, 8'h08, 0);
        chk("cmp0", rd, 3);
        apb(1, 8'h00, 1);
        while (m0 !== 1'b1) @(posedge clk);
        t = tog;
        for (k = 1; k <= 4; k++) begin
            @(posedge clk);
            chk("m0 period", {31'h0, m0}, (k == 4) ? 1 : 0);
        end
        chk("toggle", {31'h0, tog}, {31'h0, ~t});
        chk("m1", {31'h0, m1}, 1);
        apb(0, 8'h14, 0);
        chk("stat", rd, 7);
        chk("irq", {31'h0, irq}, 1);
        // Compare 1 above compare 0, unused cc2 parked at FFFFH
        apb(1, 8'h0C, 5);
        apb(1, 8'h10, 32'h0000FFFF);
        apb(1, 8'h14, 15);
        cap <= 1'b1;
        cyc(3);
        cap <= 1'b0;
        cyc(20);
        apb(0, 8'h14, 0);
        chk("stat above", rd, 1);
        apb(0, 8'h10, 0);
        chk("cc2", rd, 32'h0000FFFF);
        // All matches and the capture masked by software
        apb(1, 8'h18, 15);
        cyc(1);
        chk("irq masked", {31'h0, irq}, 0);
        for (k = 0; k < 8; k++) begin
            @(posedge clk);
            chk("m0 masked", {31'h0, m0}, 0);
        end
        // Compare 0 lowered below the running count
        apb(1, 8'h08, 200);
        do apb(0, 8'h04, 0); while (rd < 120);
        apb(1, 8'h08, 50);
        cyc(10);
        apb(0, 8'h04, 0);
        chk("no early clear", {31'h0, rd > 120}, 1);
        // Stop, lower compare 0, restart on event edges
        apb(1, 8'h00, 0);
        apb(0, 8'h04, 0);
        chk("stopped", rd, 0);
        apb(1, 8'h08, 3);
        apb(1, 8'h00, 9);
        for (k = 0; k < 3; k++) begin
            ev <= 1'b1;
            cyc(3);
            ev <= 1'b0;
            cyc(3);
        end
        cyc(3);
        apb(0, 8'h04, 0);
        chk("events", rd, 2);
        // Free-run with capture selected
        apb(1, 8'h00, 0);
        apb(1, 8'h14, 15);
        apb(1, 8'h00, 32'h00000013);
        cap <= 1'b1;
        cyc(3);
        cap <= 1'b0;
        cyc(5);
        apb(0, 8'h14, 0);
        chk("capture", {31'h0, rd[3]}, 1);
        // Pulse width: capture on the third edge, count restarts
        apb(1, 8'h00, 0);
        apb(1, 8'h00, 5);
        cap <= 1'b1;
        cyc(3);
        cap <= 1'b0;
        cyc(2);
        apb(0, 8'h10, 0);
        chk("pw capture", rd, 2);
        apb(0, 8'h04, 0);
        chk("pw restart", rd, 5);
        // Reset in mid-run: control, compare 0 and the buffers cleared
        nrst <= 1'b0;
        cyc(2);
        nrst <= 1'b1;
        cyc(1);
        apb(0, 8'h00, 0);
        chk("ctrl after reset", rd, 0);
        apb(0, 8'h08, 0);
        chk("cmp0 after reset", rd, 0);
        apb(1, 8'h00, 1);
        apb(0, 8'h14, 0);
        chk("buffers after reset", rd, 7);
        tally_and_finish;
    end
endmodule // testbench
